//--- include/cdsr_pkg.sv
// Constants and types for the serial control-register block of a CD DSP.
// Assumes a single 20 MHz system clock; all pins arrive synchronous to it.
// Operation
// - Write is data nibble then address nibble
// - Data sampled on serial clock rising edge
// - Latch pulse moves shift byte into register
// - Reset low clears every control register
// - Address 1010 holds sync and attenuator bits
// - Attenuator mode cuts audio by twelve decibels
// - Without attenuation, mute input silences audio
// - Count write presets counter from both buffers
// - Phase mode compares frame clocks /4 or /8
// - Bottom hold period is RFC/32 or /16
// - Peak hold period is RFC/4 or /2
// - Gain bit low gives quarter-duty motor drive in coarse and hold modes
// - Status shows item of last latched address
// - Addresses 1011 to 1110 select other registers
// - Tracking count starts at latch rising edge
// - Status shows complete, count, long-pulse flag
package cdsr_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_SYNC_PROTECT_ATTEN = 4'ha;
  localparam logic [3:0] ADDR_TRACK_COUNT_LOW    = 4'hb;
  localparam logic [3:0] ADDR_TRACK_COUNT_HIGH   = 4'hc;
  localparam logic [3:0] ADDR_SPINDLE_LOOP_CTRL  = 4'hd;
  localparam logic [3:0] ADDR_SPINDLE_MODE       = 4'he;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          SHIFT_WIDTH          = 8;
  localparam int          SYNC_GUARD_HI_BIT    = 3;
  localparam int          SYNC_GUARD_LO_BIT    = 2;
  localparam int          WINDOW_WIDTH_BIT     = 1;
  localparam int          ATTEN_MODE_BIT       = 0;
  localparam int          SPIN_DIV_BIT         = 3;
  localparam int          SPIN_BOTTOM_BIT      = 2;
  localparam int          SPIN_PEAK_BIT        = 1;
  localparam int          SPIN_GAIN_BIT        = 0;
  localparam logic [3:0]  REG_RESET            = 4'h0;
  localparam logic [7:0]  SHIFT_RESET          = 8'h00;
  localparam logic [8:0]  COUNT_FULL           = 9'h100;
  localparam int          ATTEN_SHIFT          = 2;
  localparam int          PERIOD_WIDTH         = 16;

  // ----------------------------------------------------------------
  // Spindle mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_STOP   = 4'h0;
  localparam logic [3:0] MODE_KICK   = 4'h8;
  localparam logic [3:0] MODE_BRAKE  = 4'ha;
  localparam logic [3:0] MODE_COARSE = 4'he;
  localparam logic [3:0] MODE_HOLD   = 4'hc;
  localparam logic [3:0] MODE_PHASE  = 4'hf;
  localparam logic [3:0] MODE_AUTO   = 4'h6;

  typedef enum logic [2:0] {
    SP_STOP, SP_KICK, SP_BRAKE, SP_COARSE, SP_HOLD, SP_PHASE
  } cdsr_spin_t;

endpackage : cdsr_pkg

//--- include/cdsr_spin_if.sv
// Carrier between the register block and the spindle drive logic.
// Assumes both ends sit on the same system clock.
`timescale 1ns/1ps
interface cdsr_spin_if;
  logic [3:0] loop_ctrl;
  logic [3:0] mode_code;

  modport ctrl (output loop_ctrl, output mode_code);
  modport spin (input loop_ctrl, input mode_code);
endinterface : cdsr_spin_if

//--- hdl/cdsr_spindle.sv
// Spindle drive: hold strobes, phase comparator and gain gating.
// Assumes the frame clocks are slow levels synchronous to sys_clk.
`timescale 1ns/1ps
module cdsr_spindle
  import cdsr_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  rstn,
  cdsr_spin_if.spin  sp,
  input  wire logic  reference_frame_clock,
  input  wire logic  write_frame_clock,
  input  wire logic  coarse_drive,
  output logic       primary_motor_drive,
  output logic       primary_motor_drive_oe,
  output logic       bottom_hold_strobe,
  output logic       peak_hold_strobe,
  output logic       motor_on
);

  logic                    ref_prev_q, ref_prev_d;
  logic                    wr_prev_q, wr_prev_d;
  logic [4:0]              ref_div_q, ref_div_d;
  logic [2:0]              wr_div_q, wr_div_d;
  logic                    phase_q, phase_d;
  logic [PERIOD_WIDTH-1:0] per_cnt_q, per_cnt_d;
  logic [PERIOD_WIDTH-1:0] per_len_q, per_len_d;
  logic                    drive_q, drive_d;
  logic                    oe_q, oe_d;
  logic                    bot_q, bot_d;
  logic                    peak_q, peak_d;
  logic                    on_q, on_d;
  cdsr_spin_t              mode;
  logic                    ref_rise, wr_rise, ref_tick, wr_tick, gain_win;

  // ----------------------------------------------------------------
  // Mode decode; unlisted codes behave as stop
  // ----------------------------------------------------------------
  always_comb begin
    unique case (sp.mode_code)
      MODE_KICK:               mode = SP_KICK;
      MODE_BRAKE:              mode = SP_BRAKE;
      MODE_COARSE, MODE_AUTO:  mode = SP_COARSE;
      MODE_HOLD:               mode = SP_HOLD;
      MODE_PHASE:              mode = SP_PHASE;
      default:                 mode = SP_STOP;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    ref_rise = reference_frame_clock & ~ref_prev_q;
    wr_rise  = write_frame_clock & ~wr_prev_q;
    ref_prev_d = reference_frame_clock;
    wr_prev_d  = write_frame_clock;
    ref_div_d  = ref_rise ? ref_div_q + 5'd1 : ref_div_q;
    wr_div_d   = wr_rise ? wr_div_q + 3'd1 : wr_div_q;
    // Divide both frame clocks by four or eight
    ref_tick = ref_rise & (sp.loop_ctrl[SPIN_DIV_BIT] ?
               (&ref_div_q[2:0]) : (&ref_div_q[1:0]));
    wr_tick  = wr_rise & (sp.loop_ctrl[SPIN_DIV_BIT] ?
               (&wr_div_q[2:0]) : (&wr_div_q[1:0]));
    phase_d = ref_tick ? 1'b1 : (wr_tick ? 1'b0 : phase_q);
    bot_d = ref_rise & (sp.loop_ctrl[SPIN_BOTTOM_BIT] ?
            (&ref_div_q[3:0]) : (&ref_div_q[4:0]));
    peak_d = ref_rise & (sp.loop_ctrl[SPIN_PEAK_BIT] ?
             ref_div_q[0] : (&ref_div_q[1:0]));
    // Half-rate period is measured, so the quarter window tracks speed
    if (ref_rise && ref_div_q[0]) begin
      per_len_d = per_cnt_q;
      per_cnt_d = '0;
    end else begin
      per_len_d = per_len_q;
      per_cnt_d = (&per_cnt_q) ? per_cnt_q : per_cnt_q + 1'b1;
    end
    gain_win = sp.loop_ctrl[SPIN_GAIN_BIT] |
               (per_cnt_q < (per_len_q >> 2));
    drive_d = 1'b0;
    oe_d    = 1'b1;
    unique case (mode)
      SP_STOP, SP_BRAKE: drive_d = 1'b0;
      SP_KICK:           drive_d = 1'b1;
      SP_COARSE, SP_HOLD: begin
        drive_d = coarse_drive;
        oe_d    = gain_win;
      end
      SP_PHASE:          drive_d = phase_q;
    endcase
    on_d = (mode != SP_STOP);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ref_prev_q <= 1'b0;
      wr_prev_q  <= 1'b0;
      ref_div_q  <= '0;
      wr_div_q   <= '0;
      phase_q    <= 1'b0;
      per_cnt_q  <= '0;
      per_len_q  <= '0;
      drive_q    <= 1'b0;
      oe_q       <= 1'b1;
      bot_q      <= 1'b0;
      peak_q     <= 1'b0;
      on_q       <= 1'b0;
    end else begin
      ref_prev_q <= ref_prev_d;
      wr_prev_q  <= wr_prev_d;
      ref_div_q  <= ref_div_d;
      wr_div_q   <= wr_div_d;
      phase_q    <= phase_d;
      per_cnt_q  <= per_cnt_d;
      per_len_q  <= per_len_d;
      drive_q    <= drive_d;
      oe_q       <= oe_d;
      bot_q      <= bot_d;
      peak_q     <= peak_d;
      on_q       <= on_d;
    end
  end

  assign primary_motor_drive    = drive_q;
  assign primary_motor_drive_oe = oe_q;
  assign bottom_hold_strobe     = bot_q;
  assign peak_hold_strobe       = peak_q;
  assign motor_on               = on_q;

endmodule : cdsr_spindle

//--- hdl/cdsr_top.sv
// Serial control-register bank: shift-in, latch, tracking counter,
// status selection, audio attenuation and the spindle drive.
// Assumes every pin input is synchronous to sys_clk and that the host
// holds each serial level for at least two clock periods.
`timescale 1ns/1ps
module cdsr_top
  import cdsr_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         system_reset_low,
  input  wire logic         ser_clk,
  input  wire logic         ser_data,
  input  wire logic         latch_strobe,
  input  wire logic         tracking_pulse_input,
  input  wire logic         long_pulse_flag,
  input  wire logic         mute_input,
  input  wire logic [15:0]  audio_in,
  input  wire logic         reference_frame_clock,
  input  wire logic         write_frame_clock,
  input  wire logic         coarse_drive,
  output logic              status_out,
  output logic              status_oe,
  output logic              sync_guard_select_hi,
  output logic              sync_guard_select_lo,
  output logic              window_width_select,
  output logic              attenuator_mode,
  output logic [15:0]       audio_out,
  output logic              primary_motor_drive,
  output logic              primary_motor_drive_oe,
  output logic              bottom_hold_strobe,
  output logic              peak_hold_strobe,
  output logic              motor_on
);

  import cdsr_pkg::*;

  logic [SHIFT_WIDTH-1:0] shift_q, shift_d;
  logic                   sclk_prev_q, sclk_prev_d;
  logic                   latch_prev_q, latch_prev_d;
  logic                   trk_prev_q, trk_prev_d;
  logic [3:0]             addr_q, addr_d;
  logic [3:0]             sync_q, sync_d;
  logic [3:0]             cnt_lo_q, cnt_lo_d;
  logic [3:0]             cnt_hi_q, cnt_hi_d;
  logic [3:0]             spin_ctrl_q, spin_ctrl_d;
  logic [3:0]             spin_mode_q, spin_mode_d;
  logic [8:0]             remain_q, remain_d;
  logic                   counting_q, counting_d;
  logic                   done_q, done_d;
  logic                   cnt_sig_q, cnt_sig_d;
  logic                   status_q, status_d;
  logic                   status_oe_q, status_oe_d;
  logic [15:0]            audio_q, audio_d;
  logic                   sclk_rise, latch_rise, trk_rise;
  logic [8:0]             reload;

  cdsr_spin_if spin_bus ();

  // ----------------------------------------------------------------
  // Serial capture, latch decode and tracking counter
  // ----------------------------------------------------------------
  always_comb begin
    sclk_rise  = ser_clk & ~sclk_prev_q;
    latch_rise = latch_strobe & ~latch_prev_q;
    trk_rise   = tracking_pulse_input & ~trk_prev_q;
    sclk_prev_d  = ser_clk;
    latch_prev_d = latch_strobe;
    trk_prev_d   = tracking_pulse_input;
    shift_d     = shift_q;
    addr_d      = addr_q;
    sync_d      = sync_q;
    cnt_lo_d    = cnt_lo_q;
    cnt_hi_d    = cnt_hi_q;
    spin_ctrl_d = spin_ctrl_q;
    spin_mode_d = spin_mode_q;
    remain_d    = remain_q;
    counting_d  = counting_q;
    done_d      = done_q;
    cnt_sig_d   = cnt_sig_q;
    // First bit in ends at bit 0 after eight clocks
    if (sclk_rise) begin
      shift_d = {ser_data, shift_q[SHIFT_WIDTH-1:1]};
    end
    if (latch_rise) begin
      addr_d = shift_q[7:4];
      unique case (shift_q[7:4])
        ADDR_SYNC_PROTECT_ATTEN: sync_d      = shift_q[3:0];
        ADDR_TRACK_COUNT_LOW:    cnt_lo_d    = shift_q[3:0];
        ADDR_TRACK_COUNT_HIGH:   cnt_hi_d    = shift_q[3:0];
        ADDR_SPINDLE_LOOP_CTRL:  spin_ctrl_d = shift_q[3:0];
        ADDR_SPINDLE_MODE:       spin_mode_d = shift_q[3:0];
        default: ;
      endcase
    end
    // Zero preset means a full 256 pulses
    reload = ({cnt_hi_d, cnt_lo_d} == 8'h00) ? COUNT_FULL :
             {1'b0, cnt_hi_d, cnt_lo_d};
    if (latch_rise && (shift_q[7:4] == ADDR_TRACK_COUNT_LOW ||
                       shift_q[7:4] == ADDR_TRACK_COUNT_HIGH)) begin
      remain_d   = reload;
      counting_d = 1'b1;
      done_d     = 1'b0;
      cnt_sig_d  = 1'b0;
    end else if (counting_q && trk_rise) begin
      if (remain_q == 9'd1) begin
        remain_d  = reload;
        done_d    = 1'b1;
        cnt_sig_d = ~cnt_sig_q;
      end else begin
        remain_d = remain_q - 9'd1;
      end
    end
    // System reset pin wipes every control register
    if (!system_reset_low) begin
      addr_d      = REG_RESET;
      sync_d      = REG_RESET;
      cnt_lo_d    = REG_RESET;
      cnt_hi_d    = REG_RESET;
      spin_ctrl_d = REG_RESET;
      spin_mode_d = REG_RESET;
      counting_d  = 1'b0;
      done_d      = 1'b0;
      cnt_sig_d   = 1'b0;
      remain_d    = '0;
    end
  end

  // ----------------------------------------------------------------
  // Status selection and audio path
  // ----------------------------------------------------------------
  always_comb begin
    status_d    = 1'b0;
    status_oe_d = 1'b1;
    unique case (addr_d)
      ADDR_SYNC_PROTECT_ATTEN: status_oe_d = 1'b0;
      ADDR_TRACK_COUNT_LOW:    status_d = counting_d & ~done_d;
      ADDR_TRACK_COUNT_HIGH:   status_d = cnt_sig_d;
      ADDR_SPINDLE_MODE:       status_d = long_pulse_flag;
      default:                 status_d = 1'b0;
    endcase
    // A quarter amplitude is the nearest shift to -12 dB
    if (sync_q[ATTEN_MODE_BIT]) begin
      audio_d = 16'($signed(audio_in) >>> ATTEN_SHIFT);
    end else if (mute_input) begin
      audio_d = 16'h0000;
    end else begin
      audio_d = audio_in;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      shift_q      <= SHIFT_RESET;
      sclk_prev_q  <= 1'b0;
      latch_prev_q <= 1'b1;
      trk_prev_q   <= 1'b0;
      addr_q       <= REG_RESET;
      sync_q       <= REG_RESET;
      cnt_lo_q     <= REG_RESET;
      cnt_hi_q     <= REG_RESET;
      spin_ctrl_q  <= REG_RESET;
      spin_mode_q  <= REG_RESET;
      remain_q     <= '0;
      counting_q   <= 1'b0;
      done_q       <= 1'b0;
      cnt_sig_q    <= 1'b0;
      status_q     <= 1'b0;
      status_oe_q  <= 1'b1;
      audio_q      <= 16'h0000;
    end else begin
      shift_q      <= shift_d;
      sclk_prev_q  <= sclk_prev_d;
      latch_prev_q <= latch_prev_d;
      trk_prev_q   <= trk_prev_d;
      addr_q       <= addr_d;
      sync_q       <= sync_d;
      cnt_lo_q     <= cnt_lo_d;
      cnt_hi_q     <= cnt_hi_d;
      spin_ctrl_q  <= spin_ctrl_d;
      spin_mode_q  <= spin_mode_d;
      remain_q     <= remain_d;
      counting_q   <= counting_d;
      done_q       <= done_d;
      cnt_sig_q    <= cnt_sig_d;
      status_q     <= status_d;
      status_oe_q  <= status_oe_d;
      audio_q      <= audio_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and spindle drive
  // ----------------------------------------------------------------
  assign status_out           = status_q;
  assign status_oe            = status_oe_q;
  assign sync_guard_select_hi = sync_q[SYNC_GUARD_HI_BIT];
  assign sync_guard_select_lo = sync_q[SYNC_GUARD_LO_BIT];
  assign window_width_select  = sync_q[WINDOW_WIDTH_BIT];
  assign attenuator_mode      = sync_q[ATTEN_MODE_BIT];
  assign audio_out            = audio_q;
  assign spin_bus.loop_ctrl   = spin_ctrl_q;
  assign spin_bus.mode_code   = spin_mode_q;

  cdsr_spindle u_spindle (
    .sys_clk                (sys_clk),
    .rstn                   (rstn),
    .sp                     (spin_bus.spin),
    .reference_frame_clock  (reference_frame_clock),
    .write_frame_clock      (write_frame_clock),
    .coarse_drive           (coarse_drive),
    .primary_motor_drive    (primary_motor_drive),
    .primary_motor_drive_oe (primary_motor_drive_oe),
    .bottom_hold_strobe     (bottom_hold_strobe),
    .peak_hold_strobe       (peak_hold_strobe),
    .motor_on               (motor_on)
  );

endmodule : cdsr_top

//--- test/cdsr_chk.sv
// Checker for the serial control-register block; concurrent relations.
// Assumes it is bound to cdsr_top and sees only that module's ports.
`timescale 1ns/1ps
module cdsr_chk (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        system_reset_low,
  input wire logic        latch_strobe,
  input wire logic        mute_input,
  input wire logic [15:0] audio_in,
  input wire logic        status_out,
  input wire logic        status_oe,
  input wire logic        sync_guard_select_hi,
  input wire logic        sync_guard_select_lo,
  input wire logic        window_width_select,
  input wire logic        attenuator_mode,
  input wire logic [15:0] audio_out,
  input wire logic        bottom_hold_strobe,
  input wire logic        peak_hold_strobe,
  input wire logic        motor_on,
  input wire logic        primary_motor_drive,
  input wire logic        primary_motor_drive_oe
);
  // ----
  // Quiet counter: cycles since the last latch rise or system reset
  // ----
  logic       lat_q;
  logic [1:0] quiet_q;
  logic [1:0] quiet_d;
  logic [3:0] regs;
  assign regs = {sync_guard_select_hi, sync_guard_select_lo,
                 window_width_select, attenuator_mode};
  always_comb begin
    quiet_d = quiet_q;
    if (!system_reset_low || (latch_strobe && !lat_q)) begin
      quiet_d = 2'h0;
    end else if (quiet_q != 2'h3) begin
      quiet_d = quiet_q + 2'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lat_q   <= 1'b1;
      quiet_q <= 2'h0;
    end else begin
      lat_q   <= latch_strobe;
      quiet_q <= quiet_d;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  // ----
  // Properties
  // ----
  property p_sync_clear;
    !system_reset_low |=> regs == 4'h0;
  endproperty
  a_sync_clear: assert property (p_sync_clear)
    else $error("control bits not cleared by system reset");
  property p_status_clear;
    !system_reset_low [*2] |=> status_oe && !status_out;
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status not at address zero after system reset");
  property p_motor_clear;
    !system_reset_low [*3] |=> !motor_on;
  endproperty
  a_motor_clear: assert property (p_motor_clear)
    else $error("motor still on after system reset");
  property p_regs_hold;
    quiet_q == 2'h3 |-> $stable(regs);
  endproperty
  a_regs_hold: assert property (p_regs_hold)
    else $error("control bits changed without a latch");
  property p_oe_hold;
    quiet_q == 2'h3 |-> $stable(status_oe);
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("status enable changed without a latch");
  property p_atten;
    attenuator_mode |=> $signed(audio_out) == ($signed($past(audio_in)) >>> 2);
  endproperty
  a_atten: assert property (p_atten)
    else $error("attenuated sample wrong");
  property p_mute;
    !attenuator_mode && mute_input |=> audio_out == 16'h0000;
  endproperty
  a_mute: assert property (p_mute)
    else $error("muted sample not silent");
  property p_pass;
    !attenuator_mode && !mute_input |=> audio_out == $past(audio_in);
  endproperty
  a_pass: assert property (p_pass)
    else $error("normal sample altered");
  property p_bottom_pulse;
    bottom_hold_strobe |=> !bottom_hold_strobe;
  endproperty
  a_bottom_pulse: assert property (p_bottom_pulse)
    else $error("bottom hold strobe longer than one cycle");
  property p_peak_pulse;
    peak_hold_strobe |=> !peak_hold_strobe;
  endproperty
  a_peak_pulse: assert property (p_peak_pulse)
    else $error("peak hold strobe longer than one cycle");
  // Float is only allowed in the running servo modes, never when stopped
  property p_stop_drive;
    !motor_on |-> !primary_motor_drive && primary_motor_drive_oe;
  endproperty
  a_stop_drive: assert property (p_stop_drive)
    else $error("motor drive not low and driven while stopped");
endmodule : cdsr_chk

bind cdsr_top cdsr_chk u_chk (
  .sys_clk              (sys_clk),
  .rstn                 (rstn),
  .system_reset_low     (system_reset_low),
  .latch_strobe         (latch_strobe),
  .mute_input           (mute_input),
  .audio_in             (audio_in),
  .status_out           (status_out),
  .status_oe            (status_oe),
  .sync_guard_select_hi (sync_guard_select_hi),
  .sync_guard_select_lo (sync_guard_select_lo),
  .window_width_select  (window_width_select),
  .attenuator_mode      (attenuator_mode),
  .audio_out            (audio_out),
  .bottom_hold_strobe   (bottom_hold_strobe),
  .peak_hold_strobe     (peak_hold_strobe),
  .motor_on             (motor_on),
  .primary_motor_drive    (primary_motor_drive),
  .primary_motor_drive_oe (primary_motor_drive_oe)
);

//--- test/cdsr_host.sv
// Host CPU model: shifts nibbles on the serial pins, then latches.
// Assumes tasks are entered at a falling sys_clk edge.
`timescale 1ns/1ps
module cdsr_host (
  input  wire logic sys_clk,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      latch_strobe
);
  initial begin
    ser_clk      = 1'b0;
    ser_data     = 1'b0;
    latch_strobe = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : hold
  task automatic send_nibble(input logic [3:0] v);
    for (int i = 0; i < 4; i++) begin
      ser_clk  = 1'b0;
      ser_data = v[i];
      hold(2);
      ser_clk = 1'b1;
      hold(2);
    end
    // Released line shows the inverse so a stale bit is never reused
    ser_data = ~v[3];
  endtask : send_nibble
  task automatic write(input logic [3:0] ad, input logic [3:0] dt);
    send_nibble(dt);
    send_nibble(ad);
    latch_strobe = 1'b0;
    hold(2);
    latch_strobe = 1'b1;
    hold(2);
  endtask : write
endmodule : cdsr_host

//--- test/cdsr_top_tb.sv
// Self-checking bench for cdsr_top with a host model and a scoreboard.
// Assumes cdsr_chk is bound to the design from its own file.
`timescale 1ns/1ps
module cdsr_top_tb;
  import cdsr_pkg::*;
  logic sys_clk, rstn, system_reset_low, ser_clk, ser_data, latch_strobe;
  logic tracking_pulse_input, long_pulse_flag, mute_input, coarse_drive;
  logic reference_frame_clock, write_frame_clock, probe;
  logic [15:0] audio_in, audio_out;
  logic status_out, status_oe, sg_hi, sg_lo, win_sel, att_mode;
  logic pmd, pmd_oe, bot_stb, peak_stb, motor_on;
  logic [3:0] a_m, mode_m, addr_m, r;
  logic [5:0] fc = 6'h00;
  logic [6:0] notes_q[$];
  logic [6:0] got;
  logic [6:0] exp_v;
  int err_count, tests_run;
  logic [3:0] modes [8] = '{MODE_STOP, MODE_KICK, MODE_BRAKE, MODE_COARSE,
                            MODE_HOLD, MODE_PHASE, MODE_AUTO, 4'h1};
  cdsr_host host (.sys_clk(sys_clk), .ser_clk(ser_clk),
                  .ser_data(ser_data), .latch_strobe(latch_strobe));
  cdsr_top DUT (.sys_clk(sys_clk), .rstn(rstn),
    .system_reset_low(system_reset_low), .ser_clk(ser_clk),
    .ser_data(ser_data), .latch_strobe(latch_strobe),
    .tracking_pulse_input(tracking_pulse_input),
    .long_pulse_flag(long_pulse_flag), .mute_input(mute_input),
    .audio_in(audio_in), .reference_frame_clock(reference_frame_clock),
    .write_frame_clock(write_frame_clock), .coarse_drive(coarse_drive),
    .status_out(status_out), .status_oe(status_oe),
    .sync_guard_select_hi(sg_hi), .sync_guard_select_lo(sg_lo),
    .window_width_select(win_sel), .attenuator_mode(att_mode),
    .audio_out(audio_out), .primary_motor_drive(pmd),
    .primary_motor_drive_oe(pmd_oe), .bottom_hold_strobe(bot_stb),
    .peak_hold_strobe(peak_stb), .motor_on(motor_on));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // ----
  // Free-running stimulus: samples, mute, servo level, frame clocks
  // ----
  always @(negedge sys_clk) begin
    fc                    <= fc + 6'h01;
    reference_frame_clock <= fc[4];
    write_frame_clock     <= fc[4] ^ fc[3];
    audio_in              <= 16'($urandom);
    mute_input            <= 1'($urandom);
    coarse_drive          <= 1'($urandom);
  end
  // Scoreboard: oldest note is compared whenever a probe appears
  initial begin
    forever begin
      @(posedge probe);
      got = {status_oe, status_out, sg_hi, sg_lo, win_sel, att_mode,
             motor_on};
      exp_v = notes_q.pop_front();
      tests_run++;
      if (got !== exp_v) begin
        err_count++;
        $display("BAD outputs expected %b seen %b", exp_v, got);
      end
    end
  end
  task automatic check(input logic st);
    logic mon;
    mon = mode_m inside {MODE_KICK, MODE_BRAKE, MODE_COARSE, MODE_HOLD,
                         MODE_PHASE, MODE_AUTO};
    repeat (6) @(negedge sys_clk);
    notes_q.push_back({addr_m != ADDR_SYNC_PROTECT_ATTEN, st, a_m, mon});
    probe = 1'b1;
    @(negedge sys_clk);
    probe = 1'b0;
  endtask : check
  task automatic wr(input logic [3:0] ad, input logic [3:0] dt);
    host.write(ad, dt);
    addr_m = ad;
    if (ad == ADDR_SYNC_PROTECT_ATTEN) a_m = dt;
    if (ad == ADDR_SPINDLE_MODE) mode_m = dt;
  endtask : wr
  task automatic pulse(input int n);
    repeat (n) begin
      tracking_pulse_input = 1'b1;
      repeat (2) @(negedge sys_clk);
      tracking_pulse_input = 1'b0;
      repeat (2) @(negedge sys_clk);
    end
  endtask : pulse
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (90000) @(posedge sys_clk);
    err_count++;
    conclude();
  end
  initial begin
    rstn = 1'b0;
    system_reset_low = 1'b1;
    tracking_pulse_input = 1'b0;
    long_pulse_flag = 1'b0;
    probe = 1'b0;
    a_m = 4'h0;
    mode_m = 4'h0;
    addr_m = 4'h0;
    err_count = 0;
    tests_run = 0;
    void'($urandom(32'h31e61ba3));
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    check(1'b0);
    $display("test reset done");
    r = 4'($urandom);
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_SYNC_PROTECT_ATTEN, 4'(i) ^ r);
      check(1'b0);
    end
    $display("test register a done");
    foreach (modes[i]) begin
      wr(ADDR_SPINDLE_LOOP_CTRL, 4'($urandom));
      wr(ADDR_SPINDLE_MODE, modes[i]);
      long_pulse_flag = 1'($urandom);
      check(long_pulse_flag);
      long_pulse_flag = ~long_pulse_flag;
      check(long_pulse_flag);
    end
    $display("test spindle modes done");
    foreach (modes[i]) begin
      wr(modes[i] ^ 4'h9, 4'($urandom));
      check(1'b0);
    end
    host.send_nibble(~a_m);
    wr(ADDR_SYNC_PROTECT_ATTEN, ~a_m);
    check(1'b0);
    $display("test unmapped and extra bits done");
    wr(ADDR_TRACK_COUNT_HIGH, 4'h0);
    wr(ADDR_TRACK_COUNT_LOW, 4'h3);
    check(1'b1);
    pulse(2);
    check(1'b1);
    pulse(1);
    check(1'b0);
    wr(ADDR_TRACK_COUNT_HIGH, 4'h0);
    check(1'b0);
    pulse(3);
    check(1'b1);
    pulse(3);
    check(1'b0);
    $display("test tracking counter done");
    system_reset_low = 1'b0;
    repeat (3) @(negedge sys_clk);
    system_reset_low = 1'b1;
    a_m = 4'h0;
    mode_m = 4'h0;
    addr_m = 4'h0;
    check(1'b0);
    wr(ADDR_SYNC_PROTECT_ATTEN, 4'hf);
    rstn = 1'b0;
    repeat (2) @(negedge sys_clk);
    rstn = 1'b1;
    a_m = 4'h0;
    addr_m = 4'h0;
    check(1'b0);
    $display("test resets done");
    if (notes_q.size() != 0) begin
      err_count++;
      $display("BAD queue expected 0 seen %0d", notes_q.size());
    end
    conclude();
  end
endmodule : cdsr_top_tb
